/* File: common/gat_params.svh */
`ifndef GAT_PARAMS_SVH
`define GAT_PARAMS_SVH

// Register offsets
`define GAT_OFS_CTRL 8'h00
`define GAT_OFS_LIMITS 8'h04
`define GAT_OFS_GLB_LIMIT 8'h08
`define GAT_OFS_THR_STATUS 8'h0c
`define GAT_OFS_IRQ_STATUS 8'h10
`define GAT_OFS_IRQ_MASK 8'h14
`define GAT_OFS_ACTIVE 8'h18

// Control fields
`define GAT_CTRL_SHORT_BIT 0
`define GAT_CTRL_CLOSED_BIT 1

// Limit register fields
`define GAT_LIM_BASE_LSB 0
`define GAT_LIM_MID_LSB 8
`define GAT_LIM_CEIL_LSB 16

// Status register fields
`define GAT_STS_HOLD0_LSB 4
`define GAT_STS_HOLD1_LSB 9

// Interrupt status bits
`define GAT_IRQ_SET_LSB 0
`define GAT_IRQ_CLR_LSB 2
`define GAT_IRQ_GLB_BIT 4
`define GAT_IRQ_W 5

// Reset values
`define GAT_RST_CTRL 2'h0
`define GAT_RST_LIMIT 8'h00
`define GAT_RST_MASK 5'h00

// Timing counts in core clocks and windows, activates per limit unit and global limit shifts
`define GAT_THR_WIN_CLKS 1344
`define GAT_GLB_WINS_NORMAL 16384
`define GAT_GLB_WINS_SHORT 4
`define GAT_HOLD_NORMAL 16
`define GAT_HOLD_SHORT 2
`define GAT_ACTS_PER_UNIT 4
`define GAT_GLB_SHIFT_NORMAL 16
`define GAT_GLB_SHIFT_SHORT 4

`endif

/* File: common/gat_pkg.sv */
package gat_pkg;
    typedef enum logic {
        GAT_MODE_NORMAL,
        GAT_MODE_SHORT
    } gat_mode_e;

    typedef logic [7:0] gat_limit_t;
    typedef logic [23:0] gat_count_t;
endpackage

/* File: logic/gat_act_counters.sv */
`timescale 1ns/1ps
`default_nettype none
module gat_act_counters #(
    parameter int N = 8,
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Activates and window clear
    input wire logic [N-1:0] act,
    input wire logic clear,
    // Counts, flattened
    output logic [N*W-1:0] count
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_cnt
            logic [W-1:0] cnt_reg;
            logic [W-1:0] cnt_next;
            // Saturating count; activate on the clear cycle opens the new window
            assign cnt_next = clear ? {{(W-1){1'b0}}, act[i]} :
                              (act[i] && !(&cnt_reg)) ? cnt_reg + 1'b1 : cnt_reg;
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_next;
                end
            end
            assign count[i*W +: W] = cnt_reg;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: logic/gat_top.sv */
// Summary of operation
// - Activates are counted per DIMM pair per branch each global window.
// - Global window is a whole number of 1344-clock throttle windows.
// - Normal mode: global window is 16384 throttle windows.
// - Short-window select: global window is 4 throttle windows.
// - Each per-pair activate counter is 24 bits.
// - Count above global limit sets branch overrun flag, selecting mid limit.
// - Flag holds until 16 quiet windows, or 2 in short mode.
// - After the quiet run the branch overrun flag is cleared.
// - Overrun during the hold restarts the full hold count.
// - Two-window hold only with short select set, else sixteen.
// - All window timing runs on the core clock.
// - One limit unit allows 4 activates per throttle window; 8-bit fields.
// - Closed loop off: flag selects mid limit, else base limit.
// - Base limit applies below low temperature with flag clear.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gat_params.svh"
module gat_top #(
    parameter int BRANCHES = 2,
    parameter int PAIRS = 4,
    parameter int CNT_W = 24,
    parameter int THR_WIN_CLKS = `GAT_THR_WIN_CLKS,
    parameter int GLB_WINS_NORMAL = `GAT_GLB_WINS_NORMAL,
    parameter int GLB_WINS_SHORT = `GAT_GLB_WINS_SHORT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Memory side
    input wire logic [BRANCHES*PAIRS-1:0] act_pulse,
    input wire logic [BRANCHES-1:0] temp_above_low,
    input wire logic [BRANCHES-1:0] temp_above_mid,
    output logic [BRANCHES*PAIRS-1:0] pair_throttle,
    output logic [BRANCHES*8-1:0] active_activation_limit,
    output logic [BRANCHES-1:0] global_overrun_flag,
    // Interrupt
    output logic irq
);
    import gat_pkg::*;

    localparam int NP = BRANCHES * PAIRS;
    localparam int HOLD_W = 5;
    localparam int TW_W = 10;

    function automatic logic over_global(input gat_count_t cnt, input gat_limit_t lim,
                                         input gat_mode_e mode);
        gat_count_t thr;
        thr = (mode == GAT_MODE_SHORT) ? {12'h000, lim, 4'h0} : {lim, 16'h0000};
        return (lim != 8'h00) && (cnt > thr);
    endfunction

    function automatic logic over_window(input logic [TW_W-1:0] cnt, input gat_limit_t lim);
        return (lim != 8'h00) && (cnt >= {lim, 2'b00});
    endfunction

    // Reset release
    logic rst_s1_reg;
    logic rst_sync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    // Software registers
    logic [1:0] ctrl_reg;
    logic [23:0] limits_reg;
    gat_limit_t glb_limit_reg;
    logic [`GAT_IRQ_W-1:0] irq_status_reg;
    logic [`GAT_IRQ_W-1:0] irq_mask_reg;
    logic [31:0] rdata_reg;

    gat_mode_e mode;
    logic closed_loop_enable;
    gat_limit_t base_activation_limit;
    gat_limit_t middle_activation_limit;
    gat_limit_t ceiling_activation_limit;
    assign mode = ctrl_reg[`GAT_CTRL_SHORT_BIT] ? GAT_MODE_SHORT : GAT_MODE_NORMAL;
    assign closed_loop_enable = ctrl_reg[`GAT_CTRL_CLOSED_BIT];
    assign base_activation_limit = limits_reg[`GAT_LIM_BASE_LSB +: 8];
    assign middle_activation_limit = limits_reg[`GAT_LIM_MID_LSB +: 8];
    assign ceiling_activation_limit = limits_reg[`GAT_LIM_CEIL_LSB +: 8];

    // Window timing on the core clock
    logic [10:0] thr_cnt_reg;
    logic [14:0] glb_cnt_reg;
    logic thr_end;
    logic glb_end;
    logic [14:0] glb_wins;
    assign glb_wins = (mode == GAT_MODE_SHORT) ? 15'(GLB_WINS_SHORT) : 15'(GLB_WINS_NORMAL);
    assign thr_end = (thr_cnt_reg == 11'(THR_WIN_CLKS - 1));
    assign glb_end = thr_end && (glb_cnt_reg >= glb_wins - 15'h0001);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            thr_cnt_reg <= '0;
            glb_cnt_reg <= '0;
        end else begin
            thr_cnt_reg <= thr_end ? 11'h000 : thr_cnt_reg + 11'h001;
            glb_cnt_reg <= glb_end ? 15'h0000 : (thr_end ? glb_cnt_reg + 15'h0001 : glb_cnt_reg);
        end
    end

    // Global activate counters
    logic [NP*CNT_W-1:0] act_count;
    gat_act_counters #(.N(NP), .W(CNT_W)) u_counters (
        .clock(clock),
        .rst_n(rst_sync_n),
        .act(act_pulse),
        .clear(glb_end),
        .count(act_count)
    );

    logic [NP-1:0] pair_over;
    logic [BRANCHES-1:0] branch_over;
    logic [BRANCHES-1:0] flag_reg;
    logic [BRANCHES-1:0] flag_next;
    logic [BRANCHES*HOLD_W-1:0] hold_reg;
    logic [HOLD_W-1:0] hold_need;
    logic [BRANCHES-1:0] flag_set_ev;
    logic [BRANCHES-1:0] flag_clr_ev;
    assign hold_need = (mode == GAT_MODE_SHORT) ? 5'(`GAT_HOLD_SHORT) : 5'(`GAT_HOLD_NORMAL);

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_pair
            logic [TW_W-1:0] tw_reg;
            logic thr_reg;
            assign pair_over[p] = over_global(act_count[p*CNT_W +: CNT_W], glb_limit_reg, mode);
            // Per throttle window allowance, 4 activates per limit unit
            always_ff @(posedge clock or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    tw_reg <= '0;
                    thr_reg <= 1'b0;
                end else begin
                    tw_reg <= thr_end ? {{(TW_W-1){1'b0}}, act_pulse[p]} :
                              (act_pulse[p] && !(&tw_reg)) ? tw_reg + 1'b1 : tw_reg;
                    thr_reg <= over_window(tw_reg,
                        active_activation_limit[(p/PAIRS)*8 +: 8]);
                end
            end
            assign pair_throttle[p] = thr_reg;
        end
    endgenerate

    genvar b;
    generate
        for (b = 0; b < BRANCHES; b++) begin : g_branch
            logic [HOLD_W-1:0] hold;
            logic quiet_done;
            gat_limit_t lim_next;
            assign hold = hold_reg[b*HOLD_W +: HOLD_W];
            assign branch_over[b] = |pair_over[b*PAIRS +: PAIRS];
            assign quiet_done = flag_reg[b] && !branch_over[b] && (hold + 5'h01 >= hold_need);
            assign flag_next[b] = glb_end ? (branch_over[b] || (flag_reg[b] && !quiet_done))
                                          : flag_reg[b];
            assign flag_set_ev[b] = glb_end && branch_over[b] && !flag_reg[b];
            assign flag_clr_ev[b] = glb_end && quiet_done;
            assign lim_next = (closed_loop_enable && temp_above_mid[b]) ? ceiling_activation_limit :
                              (closed_loop_enable && temp_above_low[b]) ? middle_activation_limit :
                              flag_next[b] ? middle_activation_limit :
                              base_activation_limit;
            always_ff @(posedge clock or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    hold_reg[b*HOLD_W +: HOLD_W] <= '0;
                    flag_reg[b] <= 1'b0;
                    active_activation_limit[b*8 +: 8] <= `GAT_RST_LIMIT;
                end else begin
                    if (glb_end) begin
                        // Overrun restarts the hold; quiet windows count it up
                        hold_reg[b*HOLD_W +: HOLD_W] <= (branch_over[b] || quiet_done) ? 5'h00
                            : (flag_reg[b] ? hold + 5'h01 : 5'h00);
                    end
                    flag_reg[b] <= flag_next[b];
                    active_activation_limit[b*8 +: 8] <= lim_next;
                end
            end
        end
    endgenerate
    assign global_overrun_flag = flag_reg;

    // Register access decode
    logic hit_ctrl;
    logic hit_limits;
    logic hit_glb;
    logic hit_sts;
    logic hit_irq;
    logic hit_mask;
    logic hit_active;
    assign hit_ctrl = (reg_addr == `GAT_OFS_CTRL);
    assign hit_limits = (reg_addr == `GAT_OFS_LIMITS);
    assign hit_glb = (reg_addr == `GAT_OFS_GLB_LIMIT);
    assign hit_sts = (reg_addr == `GAT_OFS_THR_STATUS);
    assign hit_irq = (reg_addr == `GAT_OFS_IRQ_STATUS);
    assign hit_mask = (reg_addr == `GAT_OFS_IRQ_MASK);
    assign hit_active = (reg_addr == `GAT_OFS_ACTIVE);

    logic [31:0] rd_mux;
    logic [31:0] throttle_status_register;
    logic [`GAT_IRQ_W-1:0] irq_events;
    logic [`GAT_IRQ_W-1:0] irq_status_next;
    assign throttle_status_register = {18'h00000, hold_reg[HOLD_W +: HOLD_W],
                                       hold_reg[0 +: HOLD_W], 2'b00, flag_reg};
    assign rd_mux = hit_ctrl ? {30'h00000000, ctrl_reg} :
                    hit_limits ? {8'h00, limits_reg} :
                    hit_glb ? {24'h000000, glb_limit_reg} :
                    hit_sts ? throttle_status_register :
                    hit_irq ? {27'h0000000, irq_status_reg} :
                    hit_mask ? {27'h0000000, irq_mask_reg} :
                    hit_active ? {16'h0000, active_activation_limit} : 32'h00000000;
    assign irq_events = {glb_end, flag_clr_ev, flag_set_ev};
    // Read clears, a new event in the same cycle survives
    assign irq_status_next = ((reg_rd && hit_irq) ? 5'h00 : irq_status_reg) | irq_events;

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_reg <= `GAT_RST_CTRL;
            limits_reg <= {`GAT_RST_LIMIT, `GAT_RST_LIMIT, `GAT_RST_LIMIT};
            glb_limit_reg <= `GAT_RST_LIMIT;
            irq_mask_reg <= `GAT_RST_MASK;
            irq_status_reg <= '0;
            rdata_reg <= '0;
        end else begin
            if (reg_wr && hit_ctrl) ctrl_reg <= reg_wdata[1:0];
            if (reg_wr && hit_limits) limits_reg <= reg_wdata[23:0];
            if (reg_wr && hit_glb) glb_limit_reg <= reg_wdata[7:0];
            if (reg_wr && hit_mask) irq_mask_reg <= reg_wdata[`GAT_IRQ_W-1:0];
            irq_status_reg <= irq_status_next;
            rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
        end
    end
    assign reg_rdata = rdata_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Checks
    logic [TW_W-1:0] tw0;
    assign tw0 = g_pair[0].tw_reg;

    sequence s_window_over0;
        glb_end && branch_over[0];
    endsequence
    sequence s_quiet_last0;
        glb_end && flag_reg[0] && !branch_over[0] && (g_branch[0].hold + 5'h01 >= hold_need);
    endsequence

    property p_flag_set;
        @(posedge clock) disable iff (!rst_sync_n) s_window_over0 |=> flag_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overrun flag not set");

    property p_flag_hold;
        @(posedge clock) disable iff (!rst_sync_n) flag_reg[0] && !glb_end |=> flag_reg[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped mid window");

    property p_flag_clear;
        @(posedge clock) disable iff (!rst_sync_n) s_quiet_last0 |=> !flag_reg[0] && hold_reg[4:0] == 5'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared after run");

    property p_hold_restart;
        @(posedge clock) disable iff (!rst_sync_n) s_window_over0 |=> hold_reg[4:0] == 5'h00;
    endproperty
    a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted");

    property p_hold_bound;
        @(posedge clock) disable iff (!rst_sync_n)
            hold_reg[4:0] < ((mode == GAT_MODE_SHORT) ? 5'h02 : 5'h10);
    endproperty
    a_hold_bound: assert property (p_hold_bound) else $error("hold count out of range");

    property p_mid_limit;
        @(posedge clock) disable iff (!rst_sync_n)
            !closed_loop_enable && flag_next[0]
            |=> active_activation_limit[7:0] == $past(middle_activation_limit);
    endproperty
    a_mid_limit: assert property (p_mid_limit) else $error("mid limit not applied");

    property p_base_limit;
        @(posedge clock) disable iff (!rst_sync_n)
            !closed_loop_enable && !flag_next[0]
            |=> active_activation_limit[7:0] == $past(base_activation_limit);
    endproperty
    a_base_limit: assert property (p_base_limit) else $error("base limit not applied");

    property p_counter_clear;
        @(posedge clock) disable iff (!rst_sync_n)
            glb_end && !act_pulse[0] |=> act_count[CNT_W-1:0] == 24'h000000;
    endproperty
    a_counter_clear: assert property (p_counter_clear) else $error("counter not cleared");

    property p_unlimited;
        @(posedge clock) disable iff (!rst_sync_n)
            active_activation_limit[7:0] == 8'h00 |=> !pair_throttle[0];
    endproperty
    a_unlimited: assert property (p_unlimited) else $error("zero limit throttled");

    property p_allowance;
        @(posedge clock) disable iff (!rst_sync_n)
            active_activation_limit[7:0] != 8'h00 && tw0 >= {active_activation_limit[7:0], 2'b00}
            |=> pair_throttle[0];
    endproperty
    a_allowance: assert property (p_allowance) else $error("allowance not enforced");

    property p_glb_on_thr;
        @(posedge clock) disable iff (!rst_sync_n) glb_end |-> thr_cnt_reg == 11'(THR_WIN_CLKS - 1);
    endproperty
    a_glb_on_thr: assert property (p_glb_on_thr) else $error("window not aligned");

    property p_irq_level;
        @(posedge clock) disable iff (!rst_sync_n)
            flag_set_ev[0] && irq_mask_reg[0] && !(reg_wr && hit_mask) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");
endmodule
`default_nettype wire

/* File: dv/gat_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gat_mem_model (
    // Core clock
    input wire logic clock,
    // Activates, one bit per DIMM pair
    output logic [7:0] act_pulse,
    // Temperature levels per branch
    output logic [1:0] temp_above_low,
    output logic [1:0] temp_above_mid
);
    initial begin
        act_pulse = '0;
        temp_above_low = '0;
        temp_above_mid = '0;
    end

    // One activate per set bit per cycle, then idle
    task automatic burst(input logic [7:0] m, input int n);
        repeat (n) begin
            @(posedge clock);
            act_pulse <= m;
        end
        @(posedge clock);
        act_pulse <= '0;
    endtask

    task automatic set_temp(input logic [1:0] lo, input logic [1:0] mid);
        @(posedge clock);
        temp_above_low <= lo;
        temp_above_mid <= mid;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gat_params.svh"
module tb;
    localparam int WIN = 16;
    localparam logic [7:0] OFS [7] = '{`GAT_OFS_CTRL, `GAT_OFS_LIMITS, `GAT_OFS_GLB_LIMIT,
        `GAT_OFS_THR_STATUS, `GAT_OFS_IRQ_MASK, `GAT_OFS_ACTIVE, 8'h1c};
    logic clock, rst_n, reg_wr, reg_rd, irq;
    logic [7:0] reg_addr, act_pulse, pair_throttle;
    logic [31:0] reg_wdata, reg_rdata, s;
    logic [1:0] temp_above_low, temp_above_mid, global_overrun_flag;
    logic [15:0] active_activation_limit;
    int failures, samples_checked;
    time t_irq, t1;

    gat_top #(.THR_WIN_CLKS(WIN), .GLB_WINS_NORMAL(6)) u_dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_pulse(act_pulse),
        .temp_above_low(temp_above_low), .temp_above_mid(temp_above_mid),
        .pair_throttle(pair_throttle), .active_activation_limit(active_activation_limit),
        .global_overrun_flag(global_overrun_flag), .irq(irq));
    gat_mem_model u_mem (.clock(clock), .act_pulse(act_pulse),
        .temp_above_low(temp_above_low), .temp_above_mid(temp_above_mid));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask

    task automatic wait_irq;
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clock);
        t_irq = $time;
        chk({31'h0, irq}, 32'h1, "irq");
    endtask

    // Wait for a global window end and clear the event bits
    task automatic win(output logic [31:0] st);
        wait_irq;
        rd(`GAT_OFS_IRQ_STATUS, st);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        $display("mismatch %0t watchdog expired", $time);
        test_done;
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        wr(`GAT_OFS_ACTIVE, 32'hffff);
        wr(8'h1c, 32'hff);
        foreach (OFS[i]) begin
            rd(OFS[i], s);
            chk(s, 32'h0, "reset or ignored write");
        end
        chk({31'h0, irq}, 32'h0, "irq idle");
        wr(`GAT_OFS_LIMITS, 32'h00050301);
        wr(`GAT_OFS_IRQ_MASK, 32'h10);
        u_mem.set_temp(2'b11, 2'b11);
        // First wait only passes the first window end after reset
        win(s);
        win(s);
        t1 = t_irq;
        win(s);
        chk(32'((t_irq - t1) / 100), 32'(6 * WIN), "normal window");
        chk({16'h0, active_activation_limit}, 32'h0101, "base limit");
        wr(`GAT_OFS_CTRL, 32'h1);
        win(s);
        win(s);
        t1 = t_irq;
        win(s);
        chk(32'((t_irq - t1) / 100), 32'(4 * WIN), "short window");
        // Pair 4 stays one short of its allowance
        wait_irq;
        u_mem.burst(8'h30, 3);
        u_mem.burst(8'h20, 1);
        repeat (2) @(negedge clock);
        chk({24'h0, pair_throttle}, 32'h20, "throttle at allowance");
        repeat (WIN) @(negedge clock);
        chk({24'h0, pair_throttle}, 32'h0, "throttle window end");
        rd(`GAT_OFS_IRQ_STATUS, s);
        win(s);
        u_mem.burst(8'h01, 20);
        win(s);
        chk({30'h0, global_overrun_flag}, 32'h0, "zero limit");
        wr(`GAT_OFS_GLB_LIMIT, 32'h1);
        // Branch 1 lands exactly on the limit, branch 0 one above
        win(s);
        u_mem.burst(8'h81, 16);
        u_mem.burst(8'h01, 1);
        win(s);
        chk(s & 32'h1f, 32'h11, "set event");
        chk({30'h0, global_overrun_flag}, 32'h1, "flag set");
        chk({16'h0, active_activation_limit}, 32'h0103, "mid limit");
        rd(`GAT_OFS_THR_STATUS, s);
        chk(s & 32'h3, 32'h1, "status flag");
        win(s);
        chk({30'h0, global_overrun_flag}, 32'h1, "hold one");
        u_mem.burst(8'h02, 17);
        win(s);
        chk({30'h0, global_overrun_flag}, 32'h1, "restart");
        win(s);
        chk({30'h0, global_overrun_flag}, 32'h1, "hold after restart");
        win(s);
        chk({30'h0, global_overrun_flag}, 32'h0, "flag cleared");
        chk(s & 32'h1f, 32'h14, "clear event");
        chk({16'h0, active_activation_limit}, 32'h0101, "back to base");
        wr(`GAT_OFS_CTRL, 32'h3);
        u_mem.set_temp(2'b01, 2'b01);
        win(s);
        win(s);
        chk({16'h0, active_activation_limit}, 32'h0105, "ceiling and base");
        u_mem.set_temp(2'b10, 2'b00);
        win(s);
        win(s);
        chk({16'h0, active_activation_limit}, 32'h0301, "middle and base");
        wr(`GAT_OFS_CTRL, 32'h1);
        u_mem.set_temp(2'b00, 2'b00);
        // Only the branch 0 set event may raise the line
        wr(`GAT_OFS_IRQ_MASK, 32'h1);
        rd(`GAT_OFS_IRQ_STATUS, s);
        u_mem.burst(8'h01, 40);
        wait_irq;
        wr(`GAT_OFS_IRQ_MASK, 32'h0);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`GAT_OFS_IRQ_MASK, 32'h1);
        @(negedge clock);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        rd(`GAT_OFS_IRQ_STATUS, s);
        chk(s & 32'h1, 32'h1, "irq status");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        test_done;
    end
endmodule
`default_nettype wire
